// *** shared/adcc_regs.svh ***
// Register map, field positions, reset values and timing counts of the converter control
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// Byte offsets on the register bus
`define ADCC_OFS_STATUS_CONTROL 5'h00
`define ADCC_OFS_RESULT         5'h04
`define ADCC_OFS_CLOCK_CONFIG   5'h08
`define ADCC_OFS_EVT_STATUS     5'h0C
`define ADCC_OFS_EVT_CLEAR      5'h10
`define ADCC_OFS_EVT_ENABLE     5'h14

// Status and control fields
`define ADCC_SCR_DONE_BIT       7
`define ADCC_SCR_IEN_BIT        6
`define ADCC_SCR_CONT_BIT       5
`define ADCC_SCR_CH_MSB         4
`define ADCC_SCR_CH_LSB         0

// Clock configuration fields
`define ADCC_CLK_DIV_MSB        7
`define ADCC_CLK_DIV_LSB        5
`define ADCC_CLK_SRC_BIT        4

// Event bits
`define ADCC_EVT_DONE_BIT       0
`define ADCC_EVT_ABORT_BIT      1

// Reset values
`define ADCC_RST_CHANNEL        5'h1F
`define ADCC_RST_PRESCALE       3'h0
`define ADCC_RST_RESULT         8'h00
`define ADCC_RST_EVT            2'h0

// Channel codes
`define ADCC_CH_POWER_OFF       5'h1F
`define ADCC_CH_LAST_PIN        5'h07

// Conversion timing in converter clock ticks, divide by 16 last input tick and first trial code
`define ADCC_SAMPLE_LAST        3'h7
`define ADCC_BIT_MSB            3'h7
`define ADCC_BIT_LSB            3'h0
`define ADCC_CONV_TICKS_LAST    5'h0F
`define ADCC_DIV16_LAST         4'hF
`define ADCC_DAC_MID            8'h80

`endif

// *** shared/adcc_pkg.sv ***
// Types shared by the converter control modules
`default_nettype none
package adcc_pkg;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_SAMPLE,
        ADCC_BITS
    } adcc_state_t;

endpackage

`default_nettype wire

// *** rtl/adcc_clkdiv.sv ***
// Converter clock source selection and prescaler, producing a tick enable
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.svh"

module adcc_clkdiv
    import adcc_pkg::*;
(
    // System clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Raw oscillator output clock pin
    input  wire logic       osc_out_clock,
    // Configuration
    input  wire logic       clock_source_select,
    input  wire logic [2:0] clock_prescale,
    // One-cycle converter clock tick
    output logic            adc_tick
);

    logic       osc_meta;      // First synchroniser stage
    logic       osc_sync;      // Second synchroniser stage
    logic       osc_last;      // Edge detect history
    logic [3:0] div_cnt;       // Input ticks seen in this period

    // Input tick: every cycle from the bus clock, each rising edge of the oscillator
    wire        osc_rise = osc_sync & ~osc_last;
    wire        in_tick  = clock_source_select ? 1'b1 : osc_rise;
    // Divide ratio: top bit set means divide by 16, otherwise a power of two
    wire [3:0]  div_pow  = 4'(4'h1 << clock_prescale[1:0]);
    wire [3:0]  div_last = clock_prescale[2] ? `ADCC_DIV16_LAST
                                             : 4'(div_pow - 4'h1);
    wire        period_end = in_tick & (div_cnt >= div_last);

    // Oscillator pin passes two flops before the edge detector looks at it
    always_ff @(posedge clk_sys) begin
        osc_meta <= osc_out_clock;
        osc_sync <= osc_meta;
        osc_last <= osc_sync;
    end

    // Prescaler counter; a shrunken ratio ends the period at the next input tick
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_cnt  <= 4'h0;
            adc_tick <= 1'b0;
        end else begin
            adc_tick <= period_end;
            if (period_end) begin
                div_cnt <= 4'h0;
            end else if (in_tick) begin
                div_cnt <= 4'(div_cnt + 4'h1);
            end
        end
    end

    // Bus source with divide by one ticks on every cycle
    chk_div_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clock_source_select && clock_prescale == 3'h0)[*2] |=> adc_tick)
        else $error("bus clock divide by one did not tick every cycle");

    // Oscillator source only ticks after an oscillator edge was seen
    chk_osc_src: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!clock_source_select && !osc_rise) |=> !adc_tick)
        else $error("oscillator source ticked without an oscillator edge");

endmodule

`default_nettype wire

// *** rtl/adcc_top.sv ***
// Successive approximation converter control with register bus slave
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.svh"

module adcc_top
    import adcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Oscillator output clock pin
    input  wire logic        osc_out_clock,
    // Processor power modes
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    // Analog core
    input  wire logic        cmp_above,
    output logic [4:0]       channel_select,
    output logic [7:0]       dac_code,
    output logic             sample_hold,
    output logic             adc_power_off,
    output logic             adc_settling,
    // Port pin override
    output logic [7:0]       analog_pin_sel,
    // Interrupt and wake-up
    output logic             irq,
    output logic             wake_req
);

    adcc_state_t state;            // Sequencer state
    adcc_state_t next_state;
    logic        conv_int_enable;  // Interrupt enable bit
    logic        conv_done_flag;   // Completion flag
    logic        continuous_conv;  // Continuous mode bit
    logic [2:0]  clock_prescale;   // Prescaler code
    logic        clock_source_select; // 1 selects bus clock
    logic [7:0]  adc_result;       // Result register
    logic        irq_pend;         // Pending conversion interrupt
    logic [1:0]  evt_status;       // Sticky events
    logic [1:0]  evt_enable;       // Event interrupt enables
    logic        run_req;          // A conversion is owed after stop
    logic        stop_last;        // Stop mode history for exit detect
    logic [2:0]  samp_cnt;         // Sample phase tick counter
    logic [2:0]  bit_idx;          // Bit under trial
    logic [4:0]  conv_ticks;       // Ticks since start, checking only
    logic        cmp_meta;         // Comparator first stage
    logic        cmp_sync;         // Comparator second stage
    logic        adc_tick;         // Converter clock enable
    logic [7:0]  next_dac;
    logic [2:0]  next_samp;
    logic [2:0]  next_bit;

    // Bus decode; a request is taken on the edge where waitrequest is low
    wire        bus_take   = ~avs_waitrequest;
    wire        lane0      = avs_byteenable[0];
    wire        hit_scr    = avs_address == `ADCC_OFS_STATUS_CONTROL;
    wire        hit_res    = avs_address == `ADCC_OFS_RESULT;
    wire        hit_clk    = avs_address == `ADCC_OFS_CLOCK_CONFIG;
    wire        hit_evs    = avs_address == `ADCC_OFS_EVT_STATUS;
    wire        hit_evc    = avs_address == `ADCC_OFS_EVT_CLEAR;
    wire        hit_eve    = avs_address == `ADCC_OFS_EVT_ENABLE;
    wire        wr_scr     = bus_take & avs_write & lane0 & hit_scr;
    wire        wr_clk     = bus_take & avs_write & lane0 & hit_clk;
    wire        wr_evc     = bus_take & avs_write & lane0 & hit_evc;
    wire        wr_eve     = bus_take & avs_write & lane0 & hit_eve;
    wire        rd_res     = bus_take & avs_read & hit_res;
    wire [4:0]  wr_ch      = avs_writedata[`ADCC_SCR_CH_MSB:`ADCC_SCR_CH_LSB];
    wire        wr_off     = wr_ch == `ADCC_CH_POWER_OFF;

    // Read values; the flag is masked while interrupts are enabled
    wire        done_vis   = conv_done_flag & ~conv_int_enable;
    wire [7:0]  scr_val    = {done_vis, conv_int_enable, continuous_conv, channel_select};
    wire [7:0]  clk_val    = {clock_prescale, clock_source_select, 4'h0};
    wire [7:0]  rd_mux     = hit_scr ? scr_val
                           : hit_res ? adc_result
                           : hit_clk ? clk_val
                           : hit_evs ? {6'h00, evt_status}
                           : hit_eve ? {6'h00, evt_enable}
                           : 8'h00;

    // Sequencer events
    wire        busy       = state != ADCC_IDLE;
    wire        powered    = channel_select != `ADCC_CH_POWER_OFF;
    wire        stop_exit  = stop_last & ~stop_mode;
    wire [7:0]  bit_mask   = 8'(8'h01 << bit_idx);
    // Reserved codes convert whatever the mux delivers
    wire [7:0]  trial_res  = cmp_sync ? dac_code : (dac_code & ~bit_mask);
    wire        done_evt   = (state == ADCC_BITS) & adc_tick & (bit_idx == `ADCC_BIT_LSB)
                           & ~stop_mode & ~wr_scr;
    wire        abort_evt  = busy & (stop_mode | wr_scr);
    wire        pin_chan   = channel_select <= `ADCC_CH_LAST_PIN;
    wire [7:0]  pin_onehot = 8'(8'h01 << channel_select[2:0]);
    wire [1:0]  evt_set    = {abort_evt, done_evt};

    // Converter clock prescaler
    adcc_clkdiv u_clkdiv (
        .clk_sys             (clk_sys),
        .rst_b               (rst_b),
        .osc_out_clock       (osc_out_clock),
        .clock_source_select (clock_source_select),
        .clock_prescale      (clock_prescale),
        .adc_tick            (adc_tick)
    );

    // Comparator crosses from the analog core through two flops
    always_ff @(posedge clk_sys) begin
        cmp_meta <= cmp_above;
        cmp_sync <= cmp_meta;
    end

    // Bus answer: one wait cycle, read data loaded as waitrequest drops
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Software owned fields; the written done bit position is ignored
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            conv_int_enable     <= 1'b0;
            continuous_conv     <= 1'b0;
            channel_select      <= `ADCC_RST_CHANNEL;
            clock_prescale      <= `ADCC_RST_PRESCALE;
            clock_source_select <= 1'b0;
            evt_enable          <= `ADCC_RST_EVT;
        end else begin
            if (wr_scr) begin
                conv_int_enable <= avs_writedata[`ADCC_SCR_IEN_BIT];
                continuous_conv <= avs_writedata[`ADCC_SCR_CONT_BIT];
                channel_select  <= wr_ch;
            end
            if (wr_clk) begin
                clock_prescale      <= avs_writedata[`ADCC_CLK_DIV_MSB:`ADCC_CLK_DIV_LSB];
                clock_source_select <= avs_writedata[`ADCC_CLK_SRC_BIT];
            end
            if (wr_eve) begin
                evt_enable <= avs_writedata[1:0];
            end
        end
    end

    // Completion flag, pending interrupt and events; a set beats a clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            conv_done_flag <= 1'b0;
            irq_pend       <= 1'b0;
            adc_result     <= `ADCC_RST_RESULT;
            evt_status     <= `ADCC_RST_EVT;
        end else begin
            if (done_evt & ~conv_int_enable) begin
                conv_done_flag <= 1'b1;
            end else if (rd_res) begin
                conv_done_flag <= 1'b0;
            end
            if (done_evt & conv_int_enable) begin
                irq_pend <= 1'b1;
            end else if (rd_res | wr_scr) begin
                irq_pend <= 1'b0;
            end
            if (done_evt) begin
                adc_result <= trial_res;
            end
            evt_status <= evt_set | (evt_status & ~(wr_evc ? avs_writedata[1:0] : 2'h0));
        end
    end

    // Sequencer next state: a control write restarts unless it selects power off, stop aborts
    always_comb begin
        next_state = state;
        next_dac   = dac_code;
        next_samp  = samp_cnt;
        next_bit   = bit_idx;
        if (stop_mode) begin
            next_state = ADCC_IDLE;
        end else if (wr_scr | (stop_exit & run_req & powered)) begin
            next_state = wr_scr & wr_off ? ADCC_IDLE : ADCC_SAMPLE;
            next_samp  = 3'h0;
        end else if (adc_tick) begin
            unique case (state)
                ADCC_IDLE: begin
                    next_state = ADCC_IDLE;
                end
                ADCC_SAMPLE: begin
                    next_samp = 3'(samp_cnt + 3'h1);
                    if (samp_cnt == `ADCC_SAMPLE_LAST) begin
                        next_state = ADCC_BITS;
                        next_bit   = `ADCC_BIT_MSB;
                        next_dac   = `ADCC_DAC_MID;
                    end
                end
                ADCC_BITS: begin
                    next_dac = trial_res;
                    if (bit_idx == `ADCC_BIT_LSB) begin
                        next_state = continuous_conv ? ADCC_SAMPLE : ADCC_IDLE;
                        next_samp  = 3'h0;
                    end else begin
                        next_bit = 3'(bit_idx - 3'h1);
                        next_dac = trial_res | 8'(bit_mask >> 1);
                    end
                end
            endcase
        end
    end

    // Sequencer registers and the owed-conversion memory across stop
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state     <= ADCC_IDLE;
            dac_code  <= 8'h00;
            samp_cnt  <= 3'h0;
            bit_idx   <= 3'h0;
            run_req   <= 1'b0;
            stop_last <= 1'b0;
        end else begin
            state     <= next_state;
            dac_code  <= next_dac;
            samp_cnt  <= next_samp;
            bit_idx   <= next_bit;
            stop_last <= stop_mode;
            if (wr_scr) begin
                run_req <= ~wr_off;
            end else if (done_evt & ~continuous_conv) begin
                run_req <= 1'b0;
            end
        end
    end

    // Analog side controls; settling marks the first conversion after wake or power up
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sample_hold    <= 1'b0;
            adc_power_off  <= 1'b1;
            adc_settling   <= 1'b0;
            analog_pin_sel <= 8'h00;
        end else begin
            sample_hold   <= next_state == ADCC_SAMPLE;
            adc_power_off <= ~powered | stop_mode;
            if (stop_exit | (wr_scr & ~powered)) begin
                adc_settling <= 1'b1;
            end else if (done_evt) begin
                adc_settling <= 1'b0;
            end
            // Port logic forces this pin to analog input and reads it as zero
            analog_pin_sel <= pin_chan ? pin_onehot : 8'h00;
        end
    end

    // Interrupt level: pending conversion or enabled sticky event; wake in wait on a pending conversion only
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq      <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq      <= irq_pend | (|(evt_status & evt_enable));
            wake_req <= wait_mode & irq_pend;
        end
    end

    // Helper: converter ticks since the conversion started
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            conv_ticks <= 5'h00;
        end else if (next_state == ADCC_SAMPLE && !busy) begin
            conv_ticks <= 5'h00;
        end else if (wr_scr) begin
            conv_ticks <= 5'h00;
        end else if (done_evt) begin
            // Continuous mode stays busy, so restart the count at each completion
            conv_ticks <= 5'h00;
        end else if (busy && adc_tick) begin
            conv_ticks <= 5'(conv_ticks + 5'h01);
        end
    end

    chk_irq_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
        irq_pend |-> conv_int_enable || $past(conv_int_enable))
        else $error("pending interrupt without the enable bit");
    chk_irq_raise: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_evt && conv_int_enable |=> ##1 irq)
        else $error("enabled completion did not raise the interrupt");
    chk_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        conv_done_flag && !rd_res |=> conv_done_flag)
        else $error("done flag dropped without a result read");
    chk_flag_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(conv_done_flag) |-> !$past(conv_int_enable))
        else $error("done flag set while interrupts enabled");
    chk_irq_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rd_res || wr_scr) && !done_evt |=> !irq_pend)
        else $error("pending interrupt survived a clearing access");
    chk_conv_length: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_evt |-> conv_ticks == `ADCC_CONV_TICKS_LAST)
        else $error("conversion did not take sixteen converter ticks");
    chk_cont_repeat: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_evt && continuous_conv |=> state == ADCC_SAMPLE)
        else $error("continuous mode did not start the next conversion");
    chk_single_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_evt && !continuous_conv |=> state == ADCC_IDLE)
        else $error("single mode converted more than once");
    chk_result_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_evt |=> adc_result == $past(trial_res))
        else $error("result register not overwritten at completion");
    chk_stop_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stop_mode |=> state == ADCC_IDLE && adc_power_off)
        else $error("stop mode did not abort the conversion");
    chk_power_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        channel_select == `ADCC_CH_POWER_OFF |=> adc_power_off)
        else $error("all-ones channel code left the converter powered");
    chk_pin_force: assert property (@(posedge clk_sys) disable iff (!rst_b)
        channel_select <= `ADCC_CH_LAST_PIN |=> analog_pin_sel[$past(channel_select[2:0])])
        else $error("selected pin not forced to analog input");

endmodule

`default_nettype wire

// *** verif/adcc_analog_model.sv ***
// Behavioural analog multiplexer and comparator facing the converter control
`timescale 1ns/1ns
`default_nettype none
module adcc_analog_model (
    // Clock
    input  wire logic       clk_sys,
    // Core controls
    input  wire logic [4:0] channel_select,
    input  wire logic [7:0] dac_code,
    input  wire logic       adc_power_off,
    // Comparator result
    output logic            cmp_above
);
    logic [7:0] level;  // Input level of the selected channel
    logic       toggle = 1'b0; // Garbage source while powered off
    // Pins 0x35 + 0x10 per pin, references at full and zero scale
    assign level = (channel_select == 5'h1D) ? 8'hFF :
                   (channel_select == 5'h1E) ? 8'h00 :
                   8'h35 + {1'b0, channel_select[2:0], 4'h0};
    // A dead core gives no stable answer, so it is not allowed to look valid
    always_ff @(posedge clk_sys) begin
        toggle <= ~toggle;
    end
    // Half an LSB above the level: trial codes up to the level count as below
    assign cmp_above = adc_power_off ? toggle : (level >= dac_code);
endmodule
`default_nettype wire

// *** verif/adc_conversion_control_test.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control_test;
    logic        clk_sys = 1'b0, rst_b = 1'b0, osc = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rdata;
    logic        avs_waitrequest, cmp_above, sample_hold, adc_power_off;
    logic        adc_settling, irq, wake_req;
    logic [4:0]  channel_select;
    logic [7:0]  dac_code, analog_pin_sel;
    int          bad_count = 0, checks_done = 0, n;
    always #20 clk_sys = ~clk_sys;
    // Oscillator at one eighth of the bus rate
    always #160 osc = ~osc;
    adcc_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .osc_out_clock(osc), .stop_mode(stop_mode),
        .wait_mode(wait_mode), .cmp_above(cmp_above), .channel_select(channel_select),
        .dac_code(dac_code), .sample_hold(sample_hold), .adc_power_off(adc_power_off),
        .adc_settling(adc_settling), .analog_pin_sel(analog_pin_sel), .irq(irq),
        .wake_req(wake_req));
    adcc_analog_model core (.clk_sys(clk_sys), .channel_select(channel_select),
        .dac_code(dac_code), .adc_power_off(adc_power_off), .cmp_above(cmp_above));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus cycle, held until waitrequest is sampled low; control writes keep bit 7 zero
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_read      <= ~w;
        avs_write     <= w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
        // Registered outputs follow the accepting edge by one more edge
        @(posedge clk_sys);
    endtask
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic t_reset;
        bus(0, 5'h00, 8'h00); chk("control", 32'h1F, rdata);
        bus(0, 5'h08, 8'h00); chk("clock_cfg", 32'h00, rdata);
        chk("irq", 1'b0, irq);
        chk("power_off", 1'b1, adc_power_off);
        $display("reset test done");
    endtask
    // Conversion time for every prescaler code and both sources
    task automatic t_timing;
        logic [7:0] cfg [8];
        int         per [8];
        // Comparator crosses two flops, so a tick needs three bus cycles at least;
        // divide by 1 and 2 are therefore taken on the oscillator source
        cfg = '{8'hB0, 8'hD0, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00, 8'h20};
        per = '{16, 16, 4, 8, 16, 16, 8, 16};
        for (int i = 0; i < 8; i++) begin
            bus(1, 5'h08, cfg[i]);
            bus(1, 5'h00, 8'h43);
            wait_irq();
            chk("conv_time", 1'b1, n >= 15 * per[i] && n <= 17 * per[i] + 8);
            bus(0, 5'h04, 8'h00); chk("result", 32'h65, rdata);
        end
        bus(1, 5'h08, 8'h50);
        $display("timing test done");
    endtask
    task automatic t_flag;
        bus(1, 5'h00, 8'h1D);
        n = 0;
        rdata = 32'h0;
        while (rdata[7] !== 1'b1 && n < 40) begin
            bus(0, 5'h00, 8'h00);
            n++;
        end
        chk("done_flag", 1'b1, rdata[7]);
        chk("irq_idle", 1'b0, irq);
        bus(0, 5'h04, 8'h00); chk("result_hi", 32'hFF, rdata);
        bus(0, 5'h00, 8'h00); chk("flag_clear", 1'b0, rdata[7]);
        repeat (100) @(posedge clk_sys);
        bus(0, 5'h00, 8'h00); chk("one_shot", 1'b0, rdata[7]);
        $display("flag test done");
    endtask
    task automatic t_irq;
        wait_mode <= 1'b1;
        bus(1, 5'h00, 8'h63);
        wait_irq(); chk("irq", 1'b1, irq);
        chk("wake", 1'b1, wake_req);
        bus(0, 5'h00, 8'h00); chk("flag_zero", 1'b0, rdata[7]);
        chk("pin_sel", 32'h08, analog_pin_sel);
        bus(0, 5'h04, 8'h00); chk("result", 32'h65, rdata);
        chk("irq_read", 1'b0, irq);
        wait_irq(); chk("irq_again", 1'b1, irq);
        bus(1, 5'h00, 8'h43); chk("irq_write", 1'b0, irq);
        wait_mode <= 1'b0;
        $display("interrupt test done");
    endtask
    task automatic t_stop;
        bus(1, 5'h00, 8'h25);
        repeat (8) @(posedge clk_sys);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("stop_off", 1'b1, adc_power_off);
        bus(0, 5'h0C, 8'h00); chk("abort_evt", 1'b1, rdata[1]);
        stop_mode <= 1'b0;
        n = 0;
        while (adc_settling !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        chk("settling", 1'b1, adc_settling);
        // Software lets the settling conversion pass before trusting a result
        n = 0;
        while (adc_settling !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        bus(0, 5'h04, 8'h00); chk("settled_result", 32'h85, rdata);
        bus(1, 5'h00, 8'h1F); chk("ch_off", 1'b1, adc_power_off);
        chk("pin_free", 32'h00, analog_pin_sel);
        $display("stop test done");
    endtask
    task automatic t_events;
        // Bus clock divide by one while idle: every-cycle tick path
        bus(1, 5'h08, 8'h10);
        bus(1, 5'h14, 8'h02); chk("evt_irq", 1'b1, irq);
        bus(1, 5'h14, 8'h00); chk("evt_mask", 1'b0, irq);
        bus(1, 5'h10, 8'h03);
        bus(1, 5'h14, 8'h03); chk("evt_clear", 1'b0, irq);
        bus(0, 5'h0C, 8'h00); chk("evt_status", 32'h00, rdata);
        bus(0, 5'h14, 8'h00); chk("evt_enable", 32'h03, rdata);
        bus(0, 5'h18, 8'h00); chk("unmapped", 32'h00, rdata);
        $display("event test done");
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_timing();
        t_flag();
        t_irq();
        t_stop();
        t_events();
        end_sim();
    end
    // Hang guard, well beyond the sum of all tests
    initial begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
